// >>> bench/dbf_props.sv
// port checks of the binary function bank
`timescale 1ns/10ps
`include "dbf_map.svh"
module dbf_props #(
	parameter int NUNIT = 10,
	parameter int FRAC  = 16
) (
	input logic                           clk_sys,
	input logic                           rst_b,
	input logic [`DBF_ADDR_W-1:0]         reg_addr,
	input logic [31:0]                    reg_wdata,
	input logic                           reg_wr,
	input logic                           reg_rd,
	input logic [31:0]                    reg_rdata,
	input dbf_pkg::dbf_sig_s [2*NUNIT-1:0] in_sig,
	input dbf_pkg::dbf_sig_s [NUNIT-1:0]   out_sig
);
	logic [4:0] op0_ff;
	logic [7:0] cfg0_ff;
	logic       run;

	// shadow of unit 0 mode, so the checks know which result is legal
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			op0_ff <= 5'h00;
		else if (reg_wr && reg_addr == 8'h00)
			op0_ff <= reg_wdata[4:0];
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			cfg0_ff <= 8'h00;
		else if (reg_wr && reg_addr == 8'h03)
			cfg0_ff <= reg_wdata[7:0];
	end

	assign run = op0_ff inside {[5'h01:5'h14]};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence s_op_none;
		reg_wr && reg_addr == 8'h00 && reg_wdata[4:0] == 5'h00;
	endsequence
	sequence s_op_high;
		reg_wr && reg_addr == 8'h00 && reg_wdata[4:0] > 5'h14;
	endsequence

	a_op_zero_undef: assert property (s_op_none
		|=> ##1 out_sig[0].undef)
		else $error("op 0 left output defined");
	a_op_high_undef: assert property (s_op_high
		|=> ##1 out_sig[0].undef)
		else $error("op above 20 left output defined");
	a_nodflt_undef: assert property (in_sig[0].undef && !cfg0_ff[0]
		|=> out_sig[0].undef)
		else $error("missing input did not make output undefined");
	a_dflt_fills_in: assert property (run && in_sig[0].undef
		&& cfg0_ff[0] && !in_sig[1].undef |=> !out_sig[0].undef)
		else $error("default value not substituted");
	a_valid_defined: assert property (run && !in_sig[0].undef
		&& !in_sig[1].undef |=> !out_sig[0].undef)
		else $error("defined inputs gave undefined output");
	a_unmapped_zero: assert property (reg_rd
		&& reg_addr[7:4] >= NUNIT |=> reg_rdata == 32'h0)
		else $error("unit beyond the bank answered");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_status_read: assert property (reg_rd && reg_addr == 8'h0b
		|=> reg_rdata == {31'h0, $past(out_sig[0].undef)})
		else $error("status read differs from output flag");
	a_result_read: assert property (reg_rd && reg_addr == 8'h0a
		|=> reg_rdata == $past(out_sig[0].val))
		else $error("result read differs from output value");
endmodule // dbf_props

bind dbf_top dbf_props #(.NUNIT(NUNIT), .FRAC(FRAC)) dbf_props_i (
	.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .in_sig(in_sig), .out_sig(out_sig));

// >>> bench/dbf_top_bench.sv
// self-checking bench of the binary function bank
`timescale 1ns/10ps
module dbf_top_bench;
	logic                     clk_sys;
	logic                     rst_b;
	logic [7:0]               reg_addr;
	logic [31:0]              reg_wdata;
	logic                     reg_wr;
	logic                     reg_rd;
	logic [31:0]              reg_rdata;
	dbf_pkg::dbf_sig_s [19:0] in_sig;
	dbf_pkg::dbf_sig_s [9:0]  out_sig;
	int                       n_mismatch = 0;
	int                       total_checks = 0;
	int                       cyc = 0;

	dbf_top #(.NUNIT(10), .FRAC(16)) dbf_top_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_sig(in_sig), .out_sig(out_sig));

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// gap cycle after each write keeps the strobe from being set twice
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge clk_sys);
	endtask

	// value is only meaningful while the flag is clear
	task ck(input int u, input logic un, input logic [31:0] v);
		repeat (2) @(posedge clk_sys);
		#1 chk({31'h0, out_sig[u].undef}, {31'h0, un});
		if (!un)
			chk(out_sig[u].val, v);
		@(posedge clk_sys);
	endtask

	task si(input logic u1, input logic [31:0] v1,
		input logic u2, input logic [31:0] v2);
		in_sig[0] <= {u1, v1};
		in_sig[1] <= {u2, v2};
	endtask

	task t_reset();
		ck(0, 1'b1, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h01, 32'h10000);
		rd(8'h03, 32'h0);
		rd(8'h06, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0b, 32'h1);
		wr(8'h0b, 32'h0);
		rd(8'h0b, 32'h1);
		wr(8'ha0, 32'h1f);
		rd(8'ha0, 32'h0);
		rd(8'h0c, 32'h0);
		$display("done reset");
	endtask

	// each unit must read its own pair of inputs, 2u and 2u+1
	task t_units();
		for (int u = 0; u < 10; u++)
		begin
			in_sig[2*u] <= {1'b0, 32'(u + 1) << 16};
			in_sig[2*u+1] <= {1'b0, 32'h8000};
			wr({4'(u), 4'h6}, 32'h10000);
			wr({4'(u), 4'h7}, 32'h10000);
			wr({4'(u), 4'h0}, 32'h1);
			ck(u, 1'b0, (32'(u + 1) << 16) + 32'h8000);
		end
		rd(8'h90, 32'h1);
		$display("done units");
	endtask

	task automatic t_ops();
		logic [31:0] e [1:20] = '{32'h90000, 32'h50000, 32'he0000,
			32'h38000, 32'h10000, 32'h70000, 32'h20000, 32'h0,
			32'h10000, 32'h10000, 32'h10000, 32'h0, 32'h0, 32'h10000,
			32'h10000, 32'h70000, 32'h20000, 32'h50000, 32'h1c0000,
			32'h10000};
		logic [5:0] q = 6'b101001;
		wr(8'h01, 32'h10000);
		wr(8'h06, 32'h10000);
		wr(8'h07, 32'h10000);
		si(1'b0, 32'h70000, 1'b0, 32'h20000);
		for (int k = 1; k <= 20; k++)
		begin
			wr(8'h00, 32'(k));
			ck(0, 1'b0, e[k]);
		end
		si(1'b0, 32'h20000, 1'b0, 32'h20000);
		for (int k = 8; k <= 13; k++)
		begin
			wr(8'h00, 32'(k));
			ck(0, 1'b0, {15'h0, q[k-8], 16'h0});
		end
		si(1'b0, 32'h70000, 1'b0, 32'h0);
		wr(8'h00, 32'h4);
		ck(0, 1'b0, 32'h0);
		wr(8'h00, 32'h5);
		ck(0, 1'b0, 32'h0);
		wr(8'h00, 32'h0);
		ck(0, 1'b1, 32'h0);
		wr(8'h00, 32'h15);
		ck(0, 1'b1, 32'h0);
		wr(8'h00, 32'h1f);
		ck(0, 1'b1, 32'h0);
		$display("done ops");
	endtask

	task automatic t_unary();
		logic [31:0] e [4] = '{32'hfffd0000, 32'h10000, 32'hffff0000,
			32'h30000};
		wr(8'h00, 32'h1);
		si(1'b0, 32'hfffd0000, 1'b0, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h03, 32'(k << 1));
			ck(0, 1'b0, e[k]);
		end
		si(1'b0, 32'h0, 1'b0, 32'hfffd0000);
		wr(8'h03, 32'h60);
		ck(0, 1'b0, 32'h30000);
		$display("done unary");
	endtask

	task t_dflt();
		wr(8'h03, 32'h0);
		wr(8'h04, 32'h50000);
		wr(8'h05, 32'h40000);
		rd(8'h04, 32'h50000);
		rd(8'h05, 32'h40000);
		si(1'b1, 32'h12345, 1'b0, 32'h20000);
		ck(0, 1'b1, 32'h0);
		wr(8'h03, 32'h1);
		ck(0, 1'b0, 32'h70000);
		si(1'b0, 32'h10000, 1'b1, 32'h0);
		ck(0, 1'b1, 32'h0);
		wr(8'h03, 32'h10);
		ck(0, 1'b0, 32'h50000);
		$display("done defaults");
	endtask

	task t_scale();
		wr(8'h03, 32'h0);
		si(1'b0, 32'h30000, 1'b0, 32'h0);
		wr(8'h06, 32'h20000);
		wr(8'h08, 32'h10000);
		wr(8'h01, 32'h8000);
		wr(8'h02, 32'h30000);
		ck(0, 1'b0, 32'h68000);
		rd(8'h0a, 32'h68000);
		rd(8'h06, 32'h20000);
		rd(8'h01, 32'h8000);
		rd(8'h02, 32'h30000);
		rd(8'h07, 32'h10000);
		rd(8'h09, 32'h0);
		rd(8'h0b, 32'h0);
		$display("done scale");
	endtask

	task conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		in_sig = '0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_units();
		t_ops();
		t_unary();
		t_dflt();
		t_scale();
		conclude();
	end
endmodule // dbf_top_bench

// >>> design/dbf_operand.sv
// operand stage: default substitution, unary function, scale and offset
`timescale 1ns/10ps
`include "dbf_map.svh"

module dbf_operand #(
	parameter int FRAC = 16
) (
	input  dbf_pkg::dbf_sig_s   in_sig,
	input  logic                use_dflt,
	input  dbf_pkg::dbf_val_t   dflt_val,
	input  dbf_pkg::dbf_unary_e unary,
	input  dbf_pkg::dbf_val_t   scale,
	input  dbf_pkg::dbf_val_t   offset,
	output dbf_pkg::dbf_sig_s   opnd
);

	dbf_pkg::dbf_val_t x;
	dbf_pkg::dbf_val_t fx;
	logic [31:0]       ux;

	// a missing input always takes its default value; use_dflt only decides whether the flag is cleared
	always_comb
	begin
		x = in_sig.undef ? dflt_val : in_sig.val;
		ux = dbf_pkg::to_uint(x, FRAC);
	end

	// unary map; the not forms lose the fraction by design
	always_comb
	begin
		unique case (unary)
			dbf_pkg::UN_PASS: fx = x;
			dbf_pkg::UN_LNOT: fx = dbf_pkg::from_uint({31'h0, ux == 32'h0},
				FRAC);
			dbf_pkg::UN_BNOT: fx = dbf_pkg::from_uint(~ux, FRAC);
			dbf_pkg::UN_ABS:  fx = x[31] ? -x : x;
		endcase
	end

	// scale and offset, flag carried along
	always_comb
	begin
		opnd.val = dbf_pkg::fx_mul(scale, fx, FRAC) + offset;
		opnd.undef = in_sig.undef & ~use_dflt;
	end

endmodule // dbf_operand

// >>> design/dbf_top.sv
// bank of two-input conversion units with their configuration registers
`timescale 1ns/10ps
`include "dbf_map.svh"

module dbf_top #(
	parameter int NUNIT = 10,
	parameter int FRAC  = 16
) (
	input  logic                          clk_sys,
	input  logic                          rst_b,
	input  logic [`DBF_ADDR_W-1:0]        reg_addr,
	input  logic [31:0]                   reg_wdata,
	input  logic                          reg_wr,
	input  logic                          reg_rd,
	output logic [31:0]                   reg_rdata,
	input  dbf_pkg::dbf_sig_s [2*NUNIT-1:0] in_sig,
	output dbf_pkg::dbf_sig_s [NUNIT-1:0]   out_sig
);

	// address space holds sixteen unit slots; fraction must leave an integer
	if (NUNIT < 1 || NUNIT > 16 || FRAC < 0 || FRAC > 30)
	begin : g_bad_param
		$error("dbf_top: unsupported NUNIT or FRAC");
	end

	localparam dbf_pkg::dbf_val_t ONE = dbf_pkg::from_uint(32'h1, FRAC);
	localparam dbf_pkg::dbf_val_t RST_OSCALE =
		dbf_pkg::from_uint(`DBF_RST_OSCALE, FRAC);
	localparam dbf_pkg::dbf_val_t RST_ISCALE =
		dbf_pkg::from_uint(`DBF_RST_ISCALE, FRAC);

	logic [3:0]              sel_unit;
	logic [3:0]              sel_field;
	logic [`DBF_OP_W-1:0]    op_ff      [NUNIT];
	dbf_pkg::dbf_val_t       oscale_ff  [NUNIT];
	dbf_pkg::dbf_val_t       ooffset_ff [NUNIT];
	logic [7:0]              incfg_ff   [NUNIT];
	dbf_pkg::dbf_val_t       dflt_ff    [2*NUNIT];
	dbf_pkg::dbf_val_t       scale_ff   [2*NUNIT];
	dbf_pkg::dbf_val_t       offs_ff    [2*NUNIT];
	dbf_pkg::dbf_sig_s       out_ff     [NUNIT];
	logic [31:0]             unit_rd    [NUNIT];
	logic [31:0]             nxt_rdata;
	logic [31:0]             rdata_ff;

	assign sel_unit = reg_addr[`DBF_UNIT_MSB:`DBF_UNIT_LSB];
	assign sel_field = reg_addr[`DBF_FIELD_MSB:0];

	for (genvar i = 0; i < NUNIT; i++)
	begin : g_unit
		logic               hit;
		dbf_pkg::dbf_sig_s  opa;
		dbf_pkg::dbf_sig_s  opb;
		dbf_pkg::dbf_val_t  res;
		logic               res_undef;
		logic [31:0]        ua;
		logic [31:0]        ub;
		logic signed [63:0] num;
		logic signed [63:0] quo;
		dbf_pkg::dbf_sig_s  nxt_out;
		logic [31:0]        rd_word;

		assign hit = reg_wr && (sel_unit == 4'(i));

		// operation and output stage settings
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
			begin
				op_ff[i] <= `DBF_RST_OP;
				oscale_ff[i] <= RST_OSCALE;
				ooffset_ff[i] <= `DBF_RST_VALUE;
			end
			else if (hit)
			begin
				if (sel_field == `DBF_F_OP)
					op_ff[i] <= reg_wdata[`DBF_OP_W-1:0];
				if (sel_field == `DBF_F_OSCALE)
					oscale_ff[i] <= reg_wdata;
				if (sel_field == `DBF_F_OOFFSET)
					ooffset_ff[i] <= reg_wdata;
			end
		end

		// per input substitution enables and unary selectors
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
				incfg_ff[i] <= `DBF_RST_INCFG;
			else if (hit && sel_field == `DBF_F_INCFG)
				incfg_ff[i] <= reg_wdata[7:0];
		end

		// per input default, scale and offset values
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
			begin
				dflt_ff[2*i] <= `DBF_RST_VALUE;
				dflt_ff[2*i+1] <= `DBF_RST_VALUE;
				scale_ff[2*i] <= RST_ISCALE;
				scale_ff[2*i+1] <= RST_ISCALE;
				offs_ff[2*i] <= `DBF_RST_VALUE;
				offs_ff[2*i+1] <= `DBF_RST_VALUE;
			end
			else if (hit)
			begin
				if (sel_field == `DBF_F_DFLT1)
					dflt_ff[2*i] <= reg_wdata;
				if (sel_field == `DBF_F_DFLT2)
					dflt_ff[2*i+1] <= reg_wdata;
				if (sel_field == `DBF_F_SCALE1)
					scale_ff[2*i] <= reg_wdata;
				if (sel_field == `DBF_F_SCALE2)
					scale_ff[2*i+1] <= reg_wdata;
				if (sel_field == `DBF_F_OFFS1)
					offs_ff[2*i] <= reg_wdata;
				if (sel_field == `DBF_F_OFFS2)
					offs_ff[2*i+1] <= reg_wdata;
			end
		end

		dbf_operand #(
			.FRAC     (FRAC)
		) u_opa (
			.in_sig   (in_sig[2*i]),
			.use_dflt (incfg_ff[i][`DBF_B_USEDF1]),
			.dflt_val (dflt_ff[2*i]),
			.unary    (dbf_pkg::dbf_unary_e'(
				incfg_ff[i][`DBF_B_UNARY1 +: 2])),
			.scale    (scale_ff[2*i]),
			.offset   (offs_ff[2*i]),
			.opnd     (opa)
		);

		dbf_operand #(
			.FRAC     (FRAC)
		) u_opb (
			.in_sig   (in_sig[2*i+1]),
			.use_dflt (incfg_ff[i][`DBF_B_USEDF2]),
			.dflt_val (dflt_ff[2*i+1]),
			.unary    (dbf_pkg::dbf_unary_e'(
				incfg_ff[i][`DBF_B_UNARY2 +: 2])),
			.scale    (scale_ff[2*i+1]),
			.offset   (offs_ff[2*i+1]),
			.opnd     (opb)
		);

		// integer views and the widened dividend
		always_comb
		begin
			ua = dbf_pkg::to_uint(opa.val, FRAC);
			ub = dbf_pkg::to_uint(opb.val, FRAC);
			num = {{32{opa.val[31]}}, opa.val} <<< FRAC;
			quo = (opb.val == 32'sh0) ? 64'sh0 :
				num / {{32{opb.val[31]}}, opb.val};
		end

		// the operation; a full divider per unit trades area for one cycle
		always_comb
		begin
			res = '0;
			res_undef = 1'b0;
			case (op_ff[i])
				dbf_pkg::OP_ADD:  res = opa.val + opb.val;
				dbf_pkg::OP_SUB:  res = opa.val - opb.val;
				dbf_pkg::OP_MUL:
					res = dbf_pkg::fx_mul(opa.val, opb.val, FRAC);
				dbf_pkg::OP_DIV:  res = quo[31:0];
				dbf_pkg::OP_MOD:  res = (ub == 32'h0) ? '0 :
					dbf_pkg::from_uint(ua % ub, FRAC);
				dbf_pkg::OP_MAX:
					res = (opa.val >= opb.val) ? opa.val : opb.val;
				dbf_pkg::OP_MIN:
					res = (opa.val <= opb.val) ? opa.val : opb.val;
				dbf_pkg::OP_EQ:   res = (opa.val == opb.val) ? ONE : '0;
				dbf_pkg::OP_NE:   res = (opa.val != opb.val) ? ONE : '0;
				dbf_pkg::OP_GT:   res = (opa.val > opb.val) ? ONE : '0;
				dbf_pkg::OP_GE:   res = (opa.val >= opb.val) ? ONE : '0;
				dbf_pkg::OP_LT:   res = (opa.val < opb.val) ? ONE : '0;
				dbf_pkg::OP_LE:   res = (opa.val <= opb.val) ? ONE : '0;
				dbf_pkg::OP_LOR:
					res = (ua != 32'h0 || ub != 32'h0) ? ONE : '0;
				dbf_pkg::OP_LAND:
					res = (ua != 32'h0 && ub != 32'h0) ? ONE : '0;
				dbf_pkg::OP_BOR:
					res = dbf_pkg::from_uint(ua | ub, FRAC);
				dbf_pkg::OP_BAND:
					res = dbf_pkg::from_uint(ua & ub, FRAC);
				dbf_pkg::OP_BXOR:
					res = dbf_pkg::from_uint(ua ^ ub, FRAC);
				// shifts of 32 or more clear the word
				dbf_pkg::OP_SHL:  res = (ub > 32'h1f) ? '0 :
					dbf_pkg::from_uint(ua << ub[4:0], FRAC);
				dbf_pkg::OP_SHR:  res = (ub > 32'h1f) ? '0 :
					dbf_pkg::from_uint(ua >> ub[4:0], FRAC);
				default:          res_undef = 1'b1;
			endcase
		end

		// output stage; any undefined operand spoils the result
		always_comb
		begin
			nxt_out.val = dbf_pkg::fx_mul(oscale_ff[i], res, FRAC) +
				ooffset_ff[i];
			nxt_out.undef = res_undef | opa.undef | opb.undef;
		end

		// registered every cycle so outputs track inputs with one cycle lag
		always_ff @(posedge clk_sys or negedge rst_b)
		begin
			if (!rst_b)
				out_ff[i] <= '{undef: 1'b1, val: '0};
			else
				out_ff[i] <= nxt_out;
		end

		assign out_sig[i] = out_ff[i];

		// this unit's read word; zero unless the strobe addresses it
		always_comb
		begin
			rd_word = 32'h00000000;
			if (reg_rd && sel_unit == 4'(i))
			begin
				case (sel_field)
					`DBF_F_OP:      rd_word = {27'h0, op_ff[i]};
					`DBF_F_OSCALE:  rd_word = oscale_ff[i];
					`DBF_F_OOFFSET: rd_word = ooffset_ff[i];
					`DBF_F_INCFG:   rd_word = {24'h0, incfg_ff[i]};
					`DBF_F_DFLT1:   rd_word = dflt_ff[2*i];
					`DBF_F_DFLT2:   rd_word = dflt_ff[2*i+1];
					`DBF_F_SCALE1:  rd_word = scale_ff[2*i];
					`DBF_F_SCALE2:  rd_word = scale_ff[2*i+1];
					`DBF_F_OFFS1:   rd_word = offs_ff[2*i];
					`DBF_F_OFFS2:   rd_word = offs_ff[2*i+1];
					`DBF_F_RESULT:  rd_word = out_ff[i].val;
					`DBF_F_STATUS:  rd_word = {31'h0, out_ff[i].undef};
					default:        rd_word = 32'h00000000;
				endcase
			end
		end

		assign unit_rd[i] = rd_word;
	end

	// read merge; only the addressed unit gives a nonzero word, so an or
	// needs no wide index, and slots beyond the bank read as zero
	always_comb
	begin
		nxt_rdata = 32'h00000000;
		for (int k = 0; k < NUNIT; k++)
			nxt_rdata = nxt_rdata | unit_rd[k];
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rdata_ff <= 32'h00000000;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;

endmodule // dbf_top

// >>> inc/dbf_map.svh
// register map, field positions and reset values of the binary function bank
// How it works
// - ten independent units, each with two continuous inputs and one output.
// - output is out scale times operation of scaled, offset, unary-mapped inputs plus offset.
// - an undefined input with default enabled takes the configured default value.
// - an undefined input without default enabled makes the unit output undefined.
// - unary pass returns input; absolute value negates negative inputs only.
// - logical and bitwise not work on the input as 4-byte unsigned integer.
// - operation 0 makes the output undefined regardless of inputs.
// - codes 1-4 add, subtract, multiply, divide; dividing by zero gives zero.
// - code 5 is remainder of operands taken as 4-byte unsigned integers.
// - codes 6-7 max and min; codes 8-13 compare giving 1 or 0.
// - codes 14 and 15 are logical or and logical and on unsigned integers.
// - codes 16 to 18 are bitwise or, and, xor on unsigned integers.
// - codes 19 and 20 shift first operand left or right by second.
// - each input has its own one-bit default substitution enable, 1 enables.
// - each input has its own two-bit unary selector with four choices.
`ifndef DBF_MAP_SVH
`define DBF_MAP_SVH

`define DBF_ADDR_W      8
`define DBF_UNIT_MSB    7
`define DBF_UNIT_LSB    4
`define DBF_FIELD_MSB   3

// word offsets inside one unit's slot
`define DBF_F_OP        4'h0
`define DBF_F_OSCALE    4'h1
`define DBF_F_OOFFSET   4'h2
`define DBF_F_INCFG     4'h3
`define DBF_F_DFLT1     4'h4
`define DBF_F_DFLT2     4'h5
`define DBF_F_SCALE1    4'h6
`define DBF_F_SCALE2    4'h7
`define DBF_F_OFFS1     4'h8
`define DBF_F_OFFS2     4'h9
`define DBF_F_RESULT    4'ha
`define DBF_F_STATUS    4'hb

// input config word layout
`define DBF_B_USEDF1    0
`define DBF_B_UNARY1    1
`define DBF_B_USEDF2    4
`define DBF_B_UNARY2    5
`define DBF_OP_W        5

// reset values; scales are whole numbers scaled by the fraction width
`define DBF_RST_OP      5'h00
`define DBF_RST_OSCALE  32'h00000001
`define DBF_RST_ISCALE  32'h00000000
`define DBF_RST_VALUE   32'h00000000
`define DBF_RST_INCFG   8'h00

`endif

// >>> inc/dbf_pkg.sv
// types and fixed point helpers of the binary function bank
package dbf_pkg;

	typedef logic signed [31:0] dbf_val_t;

	// value with its undefined flag
	typedef struct packed {
		logic     undef;
		dbf_val_t val;
	} dbf_sig_s;

	typedef enum logic [1:0] {
		UN_PASS,
		UN_LNOT,
		UN_BNOT,
		UN_ABS
	} dbf_unary_e;

	typedef enum logic [4:0] {
		OP_UNDEF = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_MUL = 5'h03,
		OP_DIV = 5'h04, OP_MOD = 5'h05, OP_MAX = 5'h06, OP_MIN = 5'h07,
		OP_EQ = 5'h08, OP_NE = 5'h09, OP_GT = 5'h0a, OP_GE = 5'h0b,
		OP_LT = 5'h0c, OP_LE = 5'h0d, OP_LOR = 5'h0e, OP_LAND = 5'h0f,
		OP_BOR = 5'h10, OP_BAND = 5'h11, OP_BXOR = 5'h12, OP_SHL = 5'h13,
		OP_SHR = 5'h14
	} dbf_op_e;

	// integer part as unsigned; negative values saturate to zero
	function automatic logic [31:0] to_uint(dbf_val_t x, int frac);
		dbf_val_t t;
		t = x >>> frac;
		return x[31] ? 32'h00000000 : t;
	endfunction

	function automatic dbf_val_t from_uint(logic [31:0] u, int frac);
		logic [63:0] t;
		t = {32'h00000000, u} << frac;
		return t[31:0];
	endfunction

	function automatic dbf_val_t fx_mul(dbf_val_t a, dbf_val_t b, int frac);
		logic signed [63:0] p;
		p = a * b;
		p = p >>> frac;
		return p[31:0];
	endfunction

endpackage
